// ### rtl/xcvr_cfg_consts.svh
`ifndef XCVR_CFG_CONSTS_SVH
`define XCVR_CFG_CONSTS_SVH

// ********************************************************************
// register addresses
// ********************************************************************
`define ADDR_FREQ_HIGH 4'h2
`define ADDR_MOD_SLEEP 4'h3
`define ADDR_CHECK_LIMIT 4'h4

// ********************************************************************
// field positions
// ********************************************************************
`define TUNE_UPPER_MSB 7
`define TUNE_UPPER_LSB 2
`define SUPPLY_BIT 1
`define CLKOUT_BIT 0
`define MOD_BIT 7
`define SLEEP_MSB 6
`define SLEEP_LSB 2
`define SLEEP_STRETCH_BIT 1
`define LIMIT_STRETCH_BIT 0
`define CHECK_MSB 7
`define CHECK_LSB 6
`define LIM_MSB 5
`define LIM_LSB 0

// ********************************************************************
// reset values
// ********************************************************************
`define RST_FREQ_HIGH 8'h7b
`define RST_MOD_SLEEP 8'h28
`define RST_CHECK_LIMIT 8'h50

// ********************************************************************
// timing counts in data clock periods, plain factors, and the lowest usable limit field value
// ********************************************************************
`define SLEEP_UNIT_DCLK 1024
`define SLEEP_STRETCH 8
`define LIMIT_STRETCH 2
`define TX_BIT_HALVES 2
`define LIM_MIN_USABLE 10

`endif

// ### rtl/xcvr_cfg_pkg.sv
package xcvr_cfg_pkg;

   typedef enum logic [1:0] {
      OPM_LE,
      OPM_K,
      OPM_POLL,
      OPM_RX
   } op_mode_t;

   typedef enum logic [1:0] {
      CHECK_NONE,
      CHECK_THREE,
      CHECK_SIX,
      CHECK_NINE
   } check_len_t;

   // three bits are checked per step of the selector
   function automatic logic [3:0] check_count(input check_len_t sel);
      return {2'h0, sel} * 4'h3;
   endfunction

endpackage

// ### rtl/cfg_if.sv
`timescale 1ns/1ps
interface cfg_if;
   import xcvr_cfg_pkg::*;

   logic [7:0] byte_freq;
   logic [7:0] byte_mod;
   logic [7:0] byte_check;
   logic [5:0] tune_upper;
   logic supply_en;
   logic clkout_en;
   logic mod_ask;
   logic [4:0] sleep_val;
   logic sleep_stretch;
   logic limit_stretch;
   check_len_t check_sel;
   logic [5:0] lim_val;

   modport store (output byte_freq, byte_mod, byte_check, tune_upper,
      supply_en, clkout_en, mod_ask, sleep_val, sleep_stretch,
      limit_stretch, check_sel, lim_val);
   modport use_cfg (input byte_freq, byte_mod, byte_check, tune_upper,
      supply_en, clkout_en, mod_ask, sleep_val, sleep_stretch,
      limit_stretch, check_sel, lim_val);
endinterface

// ### rtl/cfg_store.sv
`timescale 1ns/1ps
`include "xcvr_cfg_consts.svh"
module cfg_store
   import xcvr_cfg_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic wr_en,
   input wire logic [3:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic force_on,
   input wire logic aux_mode,
   cfg_if.store cfg
);
   logic [7:0] freq_reg;
   logic [7:0] freq_next;
   logic [7:0] mod_reg;
   logic [7:0] mod_next;
   logic [7:0] check_reg;
   logic [7:0] check_next;
   logic [7:0] freq_wr_val;
   logic [7:0] freq_held;
   logic [7:0] force_mask;

   // ******************************************************************
   // next values
   // ******************************************************************
   // aux supply guard
   // a clearing write in aux mode would starve the device, so keep its supply bit set
   assign freq_wr_val = wr_data | (aux_mode ? 8'h02 : 8'h00);
   assign freq_held = (wr_en && wr_addr == `ADDR_FREQ_HIGH) ?
      freq_wr_val : freq_reg;
   assign force_mask = {6'h00, 1'b1, 1'b1};
   // forced enables
   // the hardware set wins over a write landing in the same cycle
   assign freq_next = force_on ? (freq_held | force_mask) : freq_held;
   assign mod_next = (wr_en && wr_addr == `ADDR_MOD_SLEEP) ?
      wr_data : mod_reg;
   assign check_next = (wr_en && wr_addr == `ADDR_CHECK_LIMIT) ?
      wr_data : check_reg;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         freq_reg <= `RST_FREQ_HIGH;
         mod_reg <= `RST_MOD_SLEEP;
         check_reg <= `RST_CHECK_LIMIT;
      end else if (clk_en) begin
         freq_reg <= freq_next;
         mod_reg <= mod_next;
         check_reg <= check_next;
      end
   end

   // ******************************************************************
   // field decode
   // ******************************************************************
   assign cfg.byte_freq = freq_reg;
   assign cfg.byte_mod = mod_reg;
   assign cfg.byte_check = check_reg;
   assign cfg.tune_upper = freq_reg[`TUNE_UPPER_MSB:`TUNE_UPPER_LSB];
   assign cfg.supply_en = freq_reg[`SUPPLY_BIT];
   assign cfg.clkout_en = freq_reg[`CLKOUT_BIT];
   assign cfg.mod_ask = mod_reg[`MOD_BIT];
   assign cfg.sleep_val = mod_reg[`SLEEP_MSB:`SLEEP_LSB];
   assign cfg.sleep_stretch = mod_reg[`SLEEP_STRETCH_BIT];
   assign cfg.limit_stretch = mod_reg[`LIMIT_STRETCH_BIT];
   assign cfg.check_sel = check_len_t'(check_reg[`CHECK_MSB:`CHECK_LSB]);
   assign cfg.lim_val = check_reg[`LIM_MSB:`LIM_LSB];
endmodule

// ### rtl/cfg_timing.sv
`timescale 1ns/1ps
`include "xcvr_cfg_consts.svh"
module cfg_timing
   import xcvr_cfg_pkg::*;
#(
   parameter int SLEEP_W = 18,
   parameter int LIM_W = 11,
   parameter int TXB_W = 13
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic [3:0] xdclk_base,
   cfg_if.use_cfg cfg,
   output logic [SLEEP_W-1:0] sleep_dclk,
   output logic [LIM_W-1:0] lim_min_dclk,
   output logic [TXB_W-1:0] tx_bit_dclk,
   output logic [3:0] check_bits,
   output logic limit_valid
);
   logic [SLEEP_W-1:0] sleep_next;
   logic [SLEEP_W-1:0] sleep_factor;
   logic [LIM_W-1:0] xdclk;
   logic [LIM_W-1:0] lim_next;
   logic [TXB_W-1:0] txb_next;

   assign sleep_factor = cfg.sleep_stretch ?
      SLEEP_W'(`SLEEP_STRETCH) : SLEEP_W'(1);
   assign sleep_next = SLEEP_W'(cfg.sleep_val) *
      SLEEP_W'(`SLEEP_UNIT_DCLK) * sleep_factor;
   assign xdclk = LIM_W'(xdclk_base) *
      (cfg.limit_stretch ? LIM_W'(`LIMIT_STRETCH) : LIM_W'(1));
   assign lim_next = LIM_W'(cfg.lim_val) * xdclk;
   // transmit bit period, two extended clocks per unit
   assign txb_next = (TXB_W'(cfg.lim_val) + TXB_W'(1)) * TXB_W'(xdclk) *
      TXB_W'(`TX_BIT_HALVES);

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sleep_dclk <= '0;
         lim_min_dclk <= '0;
         tx_bit_dclk <= '0;
         check_bits <= 4'h0;
         limit_valid <= 1'b0;
      end else if (clk_en) begin
         sleep_dclk <= sleep_next;
         lim_min_dclk <= lim_next;
         tx_bit_dclk <= txb_next;
         check_bits <= check_count(cfg.check_sel);
         limit_valid <= (cfg.lim_val >= 6'(`LIM_MIN_USABLE));
      end
   end
endmodule

// ### rtl/transceiver_config_regs.sv
`timescale 1ns/1ps
`include "xcvr_cfg_consts.svh"
module transceiver_config_regs
   import xcvr_cfg_pkg::*;
#(
   parameter int SLEEP_W = 18,
   parameter int LIM_W = 11,
   parameter int TXB_W = 13
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic [6:0] tune_word_lower,
   input wire op_mode_t op_mode,
   input wire logic bit_check_ok,
   input wire logic key_event,
   input wire logic wakeup_flag,
   input wire logic aux_mode,
   input wire logic [3:0] xdclk_base,
   output logic [12:0] tune_word,
   output logic ext_supply_enable,
   output logic clock_out_enable,
   output logic modulation_select,
   output logic [SLEEP_W-1:0] sleep_dclk,
   output logic [LIM_W-1:0] lim_min_dclk,
   output logic [TXB_W-1:0] tx_bit_dclk,
   output logic [3:0] check_bits,
   output logic limit_valid
);
   cfg_if cfg ();

   logic force_on;
   logic check_mode;
   logic hit_freq;
   logic hit_mod;
   logic hit_check;
   logic [7:0] rd_mux;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic rvalid_reg;
   logic [12:0] tune_reg;
   logic [12:0] tune_next;
   logic supply_reg;
   logic clkout_reg;
   logic mod_reg;

   // ******************************************************************
   // decode
   // ******************************************************************
   assign hit_freq = (reg_addr == `ADDR_FREQ_HIGH);
   assign hit_mod = (reg_addr == `ADDR_MOD_SLEEP);
   assign hit_check = (reg_addr == `ADDR_CHECK_LIMIT);
   assign check_mode = (op_mode == OPM_POLL) || (op_mode == OPM_RX);
   // force sources
   // wake-up is a level, so the force repeats every cycle it is high
   assign force_on = (bit_check_ok && check_mode) || key_event ||
      wakeup_flag;

   cfg_store u_store (
      .clock(clock),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .wr_en(reg_wr),
      .wr_addr(reg_addr),
      .wr_data(reg_wdata),
      .force_on(force_on),
      .aux_mode(aux_mode),
      .cfg(cfg.store)
   );

   cfg_timing #(
      .SLEEP_W(SLEEP_W),
      .LIM_W(LIM_W),
      .TXB_W(TXB_W)
   ) u_timing (
      .clock(clock),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .xdclk_base(xdclk_base),
      .cfg(cfg.use_cfg),
      .sleep_dclk(sleep_dclk),
      .lim_min_dclk(lim_min_dclk),
      .tx_bit_dclk(tx_bit_dclk),
      .check_bits(check_bits),
      .limit_valid(limit_valid)
   );

   // ******************************************************************
   // readback
   // ******************************************************************
   // readback mux
   // other addresses belong to neighbouring blocks and read zero here
   assign rd_mux = hit_freq ? cfg.byte_freq :
      hit_mod ? cfg.byte_mod :
      hit_check ? cfg.byte_check : 8'h00;
   assign rdata_next = reg_rd ? rd_mux : rdata_reg;
   assign tune_next = {cfg.tune_upper, tune_word_lower};

   // ******************************************************************
   // output flops
   // ******************************************************************
   // output copies lag the stored field by one cycle
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rdata_reg <= 8'h00;
         rvalid_reg <= 1'b0;
         tune_reg <= 13'h0000;
         supply_reg <= 1'b1;
         clkout_reg <= 1'b1;
         mod_reg <= 1'b0;
      end else if (clk_en) begin
         rdata_reg <= rdata_next;
         rvalid_reg <= reg_rd;
         tune_reg <= tune_next;
         supply_reg <= cfg.supply_en;
         clkout_reg <= cfg.clkout_en;
         mod_reg <= cfg.mod_ask;
      end
   end

   assign reg_rdata = rdata_reg;
   assign reg_rvalid = rvalid_reg;
   assign tune_word = tune_reg;
   assign ext_supply_enable = supply_reg;
   assign clock_out_enable = clkout_reg;
   assign modulation_select = mod_reg;

   // ******************************************************************
   // assertions
   // ******************************************************************
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   a_tune_upper_write: assert property (
      clk_en && reg_wr && hit_freq |=>
         cfg.tune_upper == $past(reg_wdata[7:2]))
      else $error("upper tuning field not stored");

   a_tune_word_join: assert property (
      clk_en && reg_wr && hit_freq ##1 clk_en |=>
         tune_word == {$past(reg_wdata[7:2], 2),
         $past(tune_word_lower)})
      else $error("tuning word not joined from both fields");

   a_supply_write: assert property (
      clk_en && reg_wr && hit_freq && !force_on && !aux_mode ##1
         clk_en |=> ext_supply_enable == $past(reg_wdata[1], 2))
      else $error("supply enable does not follow write");

   a_force_enables: assert property (
      clk_en && force_on |=> cfg.supply_en && cfg.clkout_en)
      else $error("forced enables not set");

   a_force_outputs: assert property (
      clk_en && force_on ##1 clk_en |=> ext_supply_enable &&
         clock_out_enable)
      else $error("forced enables not at the outputs");

   a_aux_guard: assert property (
      clk_en && aux_mode && reg_wr && hit_freq |=> cfg.supply_en)
      else $error("supply cleared in auxiliary mode");

   a_clkout_write: assert property (
      clk_en && reg_wr && hit_freq && !force_on |=>
         cfg.clkout_en == $past(reg_wdata[0]))
      else $error("clock output bit does not follow write");

   a_mod_select: assert property (
      clk_en && reg_wr && hit_mod ##1 clk_en |=>
         modulation_select == $past(reg_wdata[7], 2))
      else $error("modulation select does not follow write");

   a_sleep_plain: assert property (
      clk_en && reg_wr && hit_mod && !reg_wdata[1] ##1 clk_en |=>
         sleep_dclk == SLEEP_W'($past(reg_wdata[6:2], 2)) *
         SLEEP_W'(`SLEEP_UNIT_DCLK))
      else $error("sleep time wrong without stretch");

   a_sleep_stretch: assert property (
      clk_en && reg_wr && hit_mod && reg_wdata[1] ##1 clk_en |=>
         sleep_dclk == SLEEP_W'($past(reg_wdata[6:2], 2)) *
         SLEEP_W'(`SLEEP_UNIT_DCLK) * SLEEP_W'(`SLEEP_STRETCH))
      else $error("sleep time wrong with stretch");

   // rst_n in the antecedent: at the release edge the flops still take
   // their reset values, not the ones worked out from the fields
   a_limit_stretch: assert property (
      rst_n && clk_en && !(reg_wr && (hit_mod || hit_check)) |=>
         !clk_en || lim_min_dclk == LIM_W'($past(cfg.lim_val)) *
         LIM_W'($past(xdclk_base)) * ($past(cfg.limit_stretch) ?
         LIM_W'(`LIMIT_STRETCH) : LIM_W'(1)))
      else $error("lower limit ignores limit stretch");

   a_check_count: assert property (
      clk_en && reg_wr && hit_check ##1 clk_en |=>
         check_bits == check_count(check_len_t'($past(reg_wdata[7:6],
         2))))
      else $error("bit check length wrong");

   a_limit_usable: assert property (
      rst_n && clk_en |=> limit_valid == ($past(cfg.lim_val) >=
         6'(`LIM_MIN_USABLE)))
      else $error("limit usable flag wrong");

   a_tx_bit_period: assert property (
      rst_n && clk_en |=> !clk_en ||
         tx_bit_dclk == (TXB_W'($past(cfg.lim_val)) +
         TXB_W'(1)) * TXB_W'($past(xdclk_base)) *
         ($past(cfg.limit_stretch) ? TXB_W'(`LIMIT_STRETCH) :
         TXB_W'(1)) * TXB_W'(`TX_BIT_HALVES))
      else $error("transmit bit period wrong");

   a_fields_hold: assert property (
      !(clk_en && (reg_wr || force_on)) |=>
         $stable(cfg.byte_freq) && $stable(cfg.byte_mod) &&
         $stable(cfg.byte_check))
      else $error("register changed without a write");

   a_read_back: assert property (
      clk_en && reg_rd && hit_check |=> reg_rvalid &&
         reg_rdata == $past(cfg.byte_check))
      else $error("readback differs from stored value");

   a_rvalid_pulse: assert property (
      rst_n && clk_en |=> reg_rvalid == $past(reg_rd))
      else $error("read valid not one cycle after the strobe");

   a_rdata_hold: assert property (
      rst_n && !(clk_en && reg_rd) |=> $stable(reg_rdata))
      else $error("read data changed without a read");

   a_read_freq: assert property (
      clk_en && reg_rd && hit_freq |=> reg_rdata == $past(cfg.byte_freq))
      else $error("tuning register readback differs");

   a_read_mod: assert property (
      clk_en && reg_rd && hit_mod |=> reg_rdata == $past(cfg.byte_mod))
      else $error("modulation register readback differs");

   a_unmapped_read: assert property (
      clk_en && reg_rd && !hit_freq && !hit_mod && !hit_check |=>
         reg_rdata == 8'h00)
      else $error("unmapped address does not read zero");

   a_unmapped_write: assert property (
      clk_en && reg_wr && !hit_freq && !hit_mod && !hit_check &&
         !force_on |=> $stable(cfg.byte_freq) && $stable(cfg.byte_mod) &&
         $stable(cfg.byte_check))
      else $error("unmapped write changed a register");

   a_clkout_output: assert property (
      clk_en && reg_wr && hit_freq && !force_on ##1 clk_en |=>
         clock_out_enable == $past(reg_wdata[0], 2))
      else $error("clock output enable does not follow write");

   a_freeze_hold: assert property (
      rst_n && !clk_en |=> $stable(tune_word) && $stable(reg_rvalid) &&
         $stable(ext_supply_enable) && $stable(clock_out_enable) &&
         $stable(modulation_select) && $stable(sleep_dclk))
      else $error("state moved while the clock enable was low");

   a_tune_lower: assert property (
      rst_n && clk_en |=> tune_word[6:0] == $past(tune_word_lower))
      else $error("lower tuning field not carried");

   a_set_wins: assert property (
      clk_en && force_on && reg_wr && hit_freq |=> cfg.supply_en &&
         cfg.clkout_en && cfg.tune_upper == $past(reg_wdata[7:2]))
      else $error("write beat the forced enables");

   a_check_mode_gate: assert property (
      clk_en && bit_check_ok && !check_mode && !key_event &&
         !wakeup_flag && !reg_wr |=> $stable(cfg.byte_freq))
      else $error("bit check forced enables outside polling or receive");

   a_aux_output: assert property (
      clk_en && aux_mode && reg_wr && hit_freq ##1 clk_en |=>
         ext_supply_enable)
      else $error("supply output dropped in auxiliary mode");

   a_tune_upper_out: assert property (
      clk_en && reg_wr && hit_freq ##1 clk_en |=>
         tune_word[12:7] == $past(reg_wdata[7:2], 2))
      else $error("upper tuning field not at the output");

   a_check_hold: assert property (
      rst_n && clk_en && !(reg_wr && hit_check) ##1 clk_en |=>
         $stable(check_bits))
      else $error("bit check length moved without a write");

   // ******************************************************************
   // coverage
   // ******************************************************************
   c_force_and_write: cover property (clk_en && force_on && reg_wr &&
      hit_freq);
   c_force_key: cover property (clk_en && key_event ##1
      ext_supply_enable == 1'b0);
   c_aux_clear: cover property (clk_en && aux_mode && reg_wr && hit_freq
      && !reg_wdata[1]);
   c_sleep_stretch: cover property (cfg.sleep_stretch &&
      cfg.sleep_val == 5'h1f);
   c_read_freq: cover property (clk_en && reg_rd && hit_freq);
endmodule

// ### bench/host_model.sv
`timescale 1ns/1ps
// ****************************************
// microcontroller side of the register port
// ****************************************
module host_model (
   input wire logic clock,
   input wire logic aux_mode,
   input wire logic break_rule,
   output logic reg_wr,
   output logic reg_rd,
   output logic [3:0] reg_addr,
   output logic [7:0] reg_wdata
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
   end

   // released lines show the inverse, so stale data never looks valid
   task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
      logic [7:0] v;
      v = d;
      if (aux_mode && !break_rule && a == 4'h2) v[1] = 1'b1;
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clock);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~v;
   endtask

   task automatic read_reg(input logic [3:0] a);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
   endtask
endmodule

// ### bench/tb.sv
`timescale 1ns/1ps
module tb;
   import xcvr_cfg_pkg::*;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic clk_en = 1'b1;
   logic [6:0] tune_word_lower = 7'h00;
   op_mode_t op_mode = OPM_LE;
   logic bit_check_ok = 1'b0;
   logic key_event = 1'b0;
   logic wakeup_flag = 1'b0;
   logic aux_mode = 1'b0;
   logic host_break = 1'b0;
   logic [3:0] xdclk_base = 4'h2;
   logic reg_wr, reg_rd;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic reg_rvalid, ext_supply_enable, clock_out_enable;
   logic modulation_select, limit_valid;
   logic [12:0] tune_word;
   logic [17:0] sleep_dclk;
   logic [10:0] lim_min_dclk;
   logic [12:0] tx_bit_dclk;
   logic [3:0] check_bits;
   logic [7:0] r2, r3, r4;
   logic [7:0] exp_q[$];
   int err_count = 0;
   int total_checks = 0;
   int i;

   always #4 clock = ~clock;

   host_model host_model_i (.clock(clock), .aux_mode(aux_mode),
      .break_rule(host_break), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata));

   transceiver_config_regs transceiver_config_regs_i (.clock(clock),
      .rst_n(rst_n), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .tune_word_lower(tune_word_lower),
      .op_mode(op_mode), .bit_check_ok(bit_check_ok),
      .key_event(key_event), .wakeup_flag(wakeup_flag),
      .aux_mode(aux_mode), .xdclk_base(xdclk_base), .tune_word(tune_word),
      .ext_supply_enable(ext_supply_enable),
      .clock_out_enable(clock_out_enable),
      .modulation_select(modulation_select), .sleep_dclk(sleep_dclk),
      .lim_min_dclk(lim_min_dclk), .tx_bit_dclk(tx_bit_dclk),
      .check_bits(check_bits), .limit_valid(limit_valid));

   // ****************************************
   // checking and closing
   // ****************************************
   task automatic summarize;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] seen,
         input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   always @(posedge clock) begin
      if (reg_rvalid === 1'b1) begin
         if (exp_q.size() == 0) check("rvalid", 1, 0);
         else check("rdata", reg_rdata, exp_q.pop_front());
      end
   end

   initial begin
      repeat (20000) @(posedge clock);
      err_count++;
      summarize();
   end

   // ****************************************
   // register traffic
   // ****************************************
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      host_model_i.write_reg(a, d);
      case (a)
         4'h2: r2 = aux_mode ? (d | 8'h02) : d;
         4'h3: r3 = d;
         4'h4: r4 = d;
         default: ;
      endcase
      repeat (3) @(posedge clock);
   endtask

   task automatic rd(input logic [3:0] a);
      int n;
      n = 0;
      exp_q.push_back(a == 2 ? r2 : a == 3 ? r3 : a == 4 ? r4 : 8'h00);
      host_model_i.read_reg(a);
      while (exp_q.size() != 0 && n < 8) begin
         @(posedge clock);
         n++;
      end
      if (exp_q.size() != 0) begin
         err_count++;
         summarize();
      end
   endtask

   task automatic check_outs;
      int lim, b, xl;
      lim = r4[5:0];
      b = xdclk_base;
      xl = r3[0] ? 2 : 1;
      check("tune_word", tune_word, {r2[7:2], tune_word_lower});
      check("supply", ext_supply_enable, r2[1]);
      check("clkout", clock_out_enable, r2[0]);
      check("modsel", modulation_select, r3[7]);
      check("sleep", sleep_dclk, r3[6:2] * 1024 * (r3[1] ? 8 : 1));
      check("lim_min", lim_min_dclk, lim * b * xl);
      check("tx_bit", tx_bit_dclk, (lim + 1) * b * xl * 2);
      check("check_bits", check_bits, int'(r4[7:6]) * 3);
      check("lim_valid", limit_valid, lim >= 10);
   endtask

   initial begin
      void'($urandom(15));
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      r2 = 8'h7b;
      r3 = 8'h28;
      r4 = 8'h50;
      repeat (3) @(posedge clock);
      check_outs();
      rd(4'h2);
      rd(4'h3);
      rd(4'h4);
      // random fields, with full and empty boundary bytes
      for (i = 0; i < 12; i++) begin
         xdclk_base <= 4'h1 << (i % 4);
         tune_word_lower <= 7'($urandom);
         wr(4'h3, 8'($urandom));
         wr(4'h4, i == 0 ? 8'hff : 8'($urandom));
         wr(4'h2, i == 1 ? 8'hff : i == 2 ? 8'h00 : 8'($urandom));
         check_outs();
         rd(4'(2 + i % 3));
      end
      // forcing sources, bit check only counts in polling and receive
      for (i = 0; i < 6; i++) begin
         wr(4'h2, 8'h00);
         op_mode <= op_mode_t'(i % 4);
         @(posedge clock);
         if (i < 4) bit_check_ok <= 1'b1;
         else if (i == 4) key_event <= 1'b1;
         else wakeup_flag <= 1'b1;
         @(posedge clock);
         bit_check_ok <= 1'b0;
         key_event <= 1'b0;
         wakeup_flag <= 1'b0;
         repeat (3) @(posedge clock);
         if (i >= 2) r2 = r2 | 8'h03;
         check_outs();
         rd(4'h2);
      end
      // clearing the supply in auxiliary mode is refused
      aux_mode <= 1'b1;
      host_break <= 1'b1;
      @(posedge clock);
      wr(4'h2, 8'h00);
      check_outs();
      rd(4'h2);
      aux_mode <= 1'b0;
      host_break <= 1'b0;
      wr(4'h5, 8'ha5);
      rd(4'h5);
      rd(4'h0);
      rd(4'hf);
      check_outs();
      // frozen clock enable takes no write
      clk_en <= 1'b0;
      host_model_i.write_reg(4'h2, 8'h55);
      repeat (2) @(posedge clock);
      clk_en <= 1'b1;
      repeat (3) @(posedge clock);
      check_outs();
      rd(4'h2);
      // second reset in mid-run restores defaults
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      r2 = 8'h7b;
      r3 = 8'h28;
      r4 = 8'h50;
      repeat (3) @(posedge clock);
      check_outs();
      rd(4'h3);
      summarize();
   end
endmodule
